// File: rtl/cfc_regs.sv
// can fifo, error state, bit timing and acceptance filter register block
// Operation
// RULE1 - buffer count code 0..6 gives 4,6,8,12,16,24,32 buffers; 7 reserved
// RULE2 - fifo start field selects first fifo buffer index 0..31
// RULE3 - read-only 6-bit pointer of next fifo write buffer
// RULE4 - read-only 6-bit pointer of next buffer software should read
// RULE5 - status bit shows transmitter bus-off
// RULE6 - separate transmitter and receiver error-passive status bits
// RULE7 - separate tx and rx warning bits plus combined either-warning bit
// RULE8 - invalid message, wake-up, error flags set by hardware, software clears only
// RULE9 - almost full, overflow, rx done, tx done flags are clear-only events
// RULE10 - error flag raised by any error-state status bit 13..8
// RULE11 - one enable bit per flag at same position, reset zero
// RULE12 - tx error counter upper byte, rx error counter lower byte, read-only
// RULE13 - jump width is field plus one quanta, 1..4
// RULE14 - quantum is two times (prescaler plus one) module clocks
// RULE15 - phase two length is field plus one quanta
// RULE16 - phase one and propagation lengths are field plus one quanta
// RULE17 - phase two select: free value, else max of phase one and ipt
// RULE18 - sampling bit picks triple or single sample of the line
// RULE19 - wake filter select applies line filter to wake-up detection
// RULE20 - sixteen filter enables, reset ones, filter accepts only when enabled
// RULE21 - steer code 0..14 picks rx buffer, 15 routes to fifo
// RULE22 - filter 0..3 steer fields at bits 3-0,7-4,11-8,15-12, reset zero
// RULE23 - wake line filter low-passes rx input during sleep
// RULE24 - interrupt request when any flag set with its enable set
`timescale 1ns/100ps
`include "cfc_defines.svh"
module cfc_regs import cfc_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // protocol engine events, one-cycle pulses
  input wire cfc_events_t evt,
  input wire cfc_err_evt_t err_evt,
  // receive line and sleep state
  input wire logic rx_line,
  input wire logic sleep_active,
  // accepted message: filter number and hit strobe
  input wire logic filter_hit,
  input wire logic [3:0] filter_hit_num,
  // derived results
  output logic irq,
  output logic accept_valid,
  output logic accept_to_fifo,
  output logic [3:0] accept_buffer,
  output logic wake_detect,
  output logic sampled_bit,
  output logic quantum_tick,
  output cfc_timing_t timing,
  output logic [5:0] buffer_total
);
  logic [2:0] buffer_count_sel;
  logic [4:0] fifo_start_index;
  logic [5:0] fifo_write_ptr;
  logic [5:0] fifo_read_ptr;
  logic [7:0] tx_error_counter;
  logic [7:0] rx_error_counter;
  logic tx_bus_off;
  logic [15:0] event_flags;
  logic [7:0] event_enables;
  logic [1:0] resync_jump_width;
  logic [5:0] quantum_prescaler;
  logic wake_line_filter_sel;
  logic [2:0] phase_two_len;
  logic phase_two_select;
  logic triple_sample_sel;
  logic [2:0] phase_one_len;
  logic [2:0] propagation_len;
  logic [15:0] filter_accept_en;
  logic [15:0] filter_zero_steer;
  cfc_bus_state_t bus_state;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [15:0] wr16;
  logic [15:0] flag_clear;
  logic [15:0] next_flags;
  logic tx_err_passive;
  logic rx_err_passive;
  logic tx_warning;
  logic rx_warning;
  logic any_warning;
  logic [5:0] fifo_last;
  logic [6:0] prescale_cnt;
  logic [2:0] samples;
  logic [3:0] wake_cnt;
  logic rx_prev;

  // status bits derived from counters
  assign tx_err_passive = !tx_bus_off && tx_error_counter >= `CFC_PASSIVE_LIMIT; // see RULE6
  assign rx_err_passive = rx_error_counter >= `CFC_PASSIVE_LIMIT; // see RULE6
  assign tx_warning = tx_error_counter >= `CFC_WARN_LIMIT; // see RULE7
  assign rx_warning = rx_error_counter >= `CFC_WARN_LIMIT; // see RULE7
  assign any_warning = tx_warning | rx_warning; // see RULE7

  // buffer count decode, reserved code treated as largest
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      buffer_total <= 6'd4;
    end else begin
      case (buffer_count_sel) // see RULE1
        3'h0: buffer_total <= 6'd4;
        3'h1: buffer_total <= 6'd6;
        3'h2: buffer_total <= 6'd8;
        3'h3: buffer_total <= 6'd12;
        3'h4: buffer_total <= 6'd16;
        3'h5: buffer_total <= 6'd24;
        default: buffer_total <= 6'd32;
      endcase
    end
  end
  assign fifo_last = buffer_total - 6'd1;

  // axi4-lite handshake: one write and one read at a time
  assign do_write = aw_held && w_held && bus_state == CFC_IDLE;
  assign wr16 = w_data[15:0];
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus_state <= CFC_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CFC_AXI_OKAY;
    end else begin
      case (bus_state)
        CFC_IDLE: begin
          if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr > `CFC_OFF_DERIVED || aw_addr[1:0] != 2'b00) ?
                `CFC_AXI_SLVERR : `CFC_AXI_OKAY;
            bus_state <= CFC_WRESP;
          end
        end
        CFC_WRESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            bus_state <= CFC_IDLE;
          end
        end
        default: bus_state <= CFC_IDLE;
      endcase
    end
  end

  // read channel runs independently
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CFC_AXI_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CFC_AXI_OKAY;
      case (s_axi_araddr)
        `CFC_OFF_FIFO_CONTROL: s_axi_rdata <= {16'h0, buffer_count_sel, 8'h0, fifo_start_index};
        `CFC_OFF_FIFO_STATUS: // see RULE3 see RULE4
          s_axi_rdata <= {16'h0, 2'b00, fifo_write_ptr, 2'b00, fifo_read_ptr};
        `CFC_OFF_EVENT_FLAGS: s_axi_rdata <= {16'h0, event_flags};
        `CFC_OFF_EVENT_ENABLES: s_axi_rdata <= {24'h0, event_enables};
        `CFC_OFF_ERROR_COUNTS: // see RULE12
          s_axi_rdata <= {16'h0, tx_error_counter, rx_error_counter};
        `CFC_OFF_BIT_TIMING_ONE: s_axi_rdata <= {24'h0, resync_jump_width, quantum_prescaler};
        `CFC_OFF_BIT_TIMING_TWO:
          s_axi_rdata <= {16'h0, 1'b0, wake_line_filter_sel, 3'b000, phase_two_len,
              phase_two_select, triple_sample_sel, phase_one_len, propagation_len};
        `CFC_OFF_FILTER_ENABLES: s_axi_rdata <= {16'h0, filter_accept_en};
        `CFC_OFF_FILTER_STEER_LOW: s_axi_rdata <= {16'h0, filter_zero_steer};
        `CFC_OFF_DERIVED: s_axi_rdata <= {21'h0, timing.phase_two, 2'b00, buffer_total};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `CFC_AXI_SLVERR;
        end
      endcase
    end
  end

  // software-written configuration
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      buffer_count_sel <= 3'h0;
      fifo_start_index <= 5'h00;
      event_enables <= 8'h00;
      resync_jump_width <= 2'h0;
      quantum_prescaler <= 6'h00;
      wake_line_filter_sel <= 1'b0;
      phase_two_len <= 3'h0;
      phase_two_select <= 1'b0;
      triple_sample_sel <= 1'b0;
      phase_one_len <= 3'h0;
      propagation_len <= 3'h0;
      filter_accept_en <= `CFC_FILTER_EN_RESET; // see RULE20
      filter_zero_steer <= 16'h0000; // see RULE22
    end else if (do_write) begin
      case (aw_addr)
        `CFC_OFF_FIFO_CONTROL: begin
          if (w_strb[1]) buffer_count_sel <= wr16[15:13]; // see RULE1
          if (w_strb[0]) fifo_start_index <= wr16[4:0]; // see RULE2
        end
        `CFC_OFF_EVENT_ENABLES: begin
          if (w_strb[0]) event_enables <= wr16[7:0] & 8'(`CFC_FLAG_MASK); // see RULE11
        end
        `CFC_OFF_BIT_TIMING_ONE: begin
          if (w_strb[0]) begin
            resync_jump_width <= wr16[7:6];
            quantum_prescaler <= wr16[5:0];
          end
        end
        `CFC_OFF_BIT_TIMING_TWO: begin
          if (w_strb[1]) begin
            wake_line_filter_sel <= wr16[14];
            phase_two_len <= wr16[10:8];
          end
          if (w_strb[0]) begin
            phase_two_select <= wr16[7];
            triple_sample_sel <= wr16[6];
            phase_one_len <= wr16[5:3];
            propagation_len <= wr16[2:0];
          end
        end
        `CFC_OFF_FILTER_ENABLES: begin
          if (w_strb[1]) filter_accept_en[15:8] <= wr16[15:8];
          if (w_strb[0]) filter_accept_en[7:0] <= wr16[7:0];
        end
        `CFC_OFF_FILTER_STEER_LOW: begin
          if (w_strb[1]) filter_zero_steer[15:8] <= wr16[15:8];
          if (w_strb[0]) filter_zero_steer[7:0] <= wr16[7:0];
        end
        default: ;
      endcase
    end
  end

  // writing zero clears a flag, writing one leaves it; a new event wins
  assign flag_clear = (do_write && aw_addr == `CFC_OFF_EVENT_FLAGS && w_strb[0]) ?
      {8'h00, ~wr16[7:0]} : 16'h0000;
  always_comb begin
    next_flags = event_flags & ~flag_clear; // see RULE8
    next_flags[7] = next_flags[7] | evt.invalid_msg; // see RULE8
    next_flags[6] = next_flags[6] | evt.wakeup | wake_detect; // see RULE8
    next_flags[5] = next_flags[5] | (|event_flags[13:8]); // see RULE10
    next_flags[3] = next_flags[3] | evt.almost_full; // see RULE9
    next_flags[2] = next_flags[2] | evt.rx_overflow; // see RULE9
    next_flags[1] = next_flags[1] | evt.rx_done; // see RULE9
    next_flags[0] = next_flags[0] | evt.tx_done; // see RULE9
    next_flags[13:8] = {tx_bus_off, tx_err_passive, rx_err_passive,
        tx_warning, rx_warning, any_warning}; // see RULE5 see RULE6 see RULE7
    next_flags[15:14] = 2'b00;
    next_flags[4] = 1'b0;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      event_flags <= 16'h0000;
      irq <= 1'b0;
    end else begin
      event_flags <= next_flags;
      irq <= |(next_flags[7:0] & event_enables); // see RULE24
    end
  end

  // error counters, saturating; bus-off sticks until reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_error_counter <= 8'h00;
      rx_error_counter <= 8'h00;
      tx_bus_off <= 1'b0;
    end else begin
      if (err_evt.tx_err && !tx_bus_off) begin
        if ({1'b0, tx_error_counter} + 9'd8 >= `CFC_BUSOFF_LIMIT) begin
          tx_bus_off <= 1'b1; // see RULE5
          tx_error_counter <= 8'hff;
        end else begin
          tx_error_counter <= tx_error_counter + 8'd8;
        end
      end else if (err_evt.tx_ok && tx_error_counter != 8'h00 && !tx_bus_off) begin
        tx_error_counter <= tx_error_counter - 8'd1;
      end
      if (err_evt.rx_err && rx_error_counter != 8'hff) begin
        rx_error_counter <= rx_error_counter + 8'd1;
      end else if (err_evt.rx_ok && rx_error_counter != 8'h00) begin
        rx_error_counter <= rx_error_counter - 8'd1;
      end
    end
  end

  // fifo pointers wrap from the last buffer back to the start index
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fifo_write_ptr <= 6'h00;
      fifo_read_ptr <= 6'h00;
    end else begin
      if (do_write && aw_addr == `CFC_OFF_FIFO_CONTROL) begin
        fifo_write_ptr <= {1'b0, wr16[4:0]}; // see RULE2
        fifo_read_ptr <= {1'b0, wr16[4:0]};
      end else begin
        if (evt.rx_push) // see RULE3
          fifo_write_ptr <= (fifo_write_ptr >= fifo_last) ? {1'b0, fifo_start_index}
              : fifo_write_ptr + 6'd1;
        if (evt.fifo_pop && fifo_read_ptr != fifo_write_ptr) // see RULE4
          fifo_read_ptr <= (fifo_read_ptr >= fifo_last) ? {1'b0, fifo_start_index}
              : fifo_read_ptr + 6'd1;
      end
    end
  end

  // timing outputs; phase two falls back to max(phase one, ipt)
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      timing <= '0;
    end else begin
      timing.sjw <= resync_jump_width; // see RULE13
      timing.prescaler <= quantum_prescaler;
      timing.phase_one <= phase_one_len; // see RULE16
      timing.propagation <= propagation_len; // see RULE16
      timing.triple_sample_sel <= triple_sample_sel;
      if (phase_two_select) // see RULE17 see RULE15
        timing.phase_two <= phase_two_len;
      else if ({1'b0, phase_one_len} + 4'h1 >= `CFC_IPT_TQ)
        timing.phase_two <= phase_one_len;
      else
        timing.phase_two <= 3'(`CFC_IPT_TQ - 4'h1);
    end
  end

  // quantum tick every 2*(prescaler+1) clocks
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prescale_cnt <= 7'h00;
      quantum_tick <= 1'b0;
    end else if (prescale_cnt >= {quantum_prescaler, 1'b1}) begin
      prescale_cnt <= 7'h00; // see RULE14
      quantum_tick <= 1'b1;
    end else begin
      prescale_cnt <= prescale_cnt + 7'h01;
      quantum_tick <= 1'b0;
    end
  end

  // majority of three quantum-spaced samples, or the latest one
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      samples <= 3'b111;
      sampled_bit <= 1'b1;
    end else if (quantum_tick) begin
      samples <= {samples[1:0], rx_line};
      sampled_bit <= triple_sample_sel ? // see RULE18
          ((samples[1] & samples[0]) | (samples[1] & rx_line) | (samples[0] & rx_line))
          : rx_line;
    end
  end

  // wake-up: filtered needs a dominant level held for several clocks
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wake_cnt <= 4'h0;
      rx_prev <= 1'b1;
      wake_detect <= 1'b0;
    end else begin
      rx_prev <= rx_line;
      wake_detect <= 1'b0;
      if (!sleep_active || rx_line) begin
        wake_cnt <= 4'h0;
      end else if (!wake_line_filter_sel) begin
        wake_detect <= rx_prev; // see RULE19
      end else if (wake_cnt == `CFC_WAKE_FILTER_LEN - 4'h1) begin
        wake_detect <= 1'b1; // see RULE23
        wake_cnt <= wake_cnt + 4'h1;
      end else if (wake_cnt < `CFC_WAKE_FILTER_LEN) begin
        wake_cnt <= wake_cnt + 4'h1;
      end
    end
  end

  // steering: only filters 0..3 have steer fields here
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      accept_valid <= 1'b0;
      accept_to_fifo <= 1'b0;
      accept_buffer <= 4'h0;
    end else begin
      accept_valid <= filter_hit && filter_accept_en[filter_hit_num]; // see RULE20
      accept_buffer <= (filter_hit_num < 4'h4) ?
          filter_zero_steer[{filter_hit_num[1:0], 2'b00} +: 4] : `CFC_STEER_FIFO; // see RULE22
      accept_to_fifo <= (filter_hit_num >= 4'h4) ||
          filter_zero_steer[{filter_hit_num[1:0], 2'b00} +: 4] == `CFC_STEER_FIFO; // see RULE21
    end
  end
endmodule

// File: inc/cfc_defines.svh
// register offsets, flag mask, reset values, limits and timing counts
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH
`define CFC_OFF_FIFO_CONTROL 8'h00
`define CFC_OFF_FIFO_STATUS 8'h04
`define CFC_OFF_EVENT_FLAGS 8'h08
`define CFC_OFF_EVENT_ENABLES 8'h0c
`define CFC_OFF_ERROR_COUNTS 8'h10
`define CFC_OFF_BIT_TIMING_ONE 8'h14
`define CFC_OFF_BIT_TIMING_TWO 8'h18
`define CFC_OFF_FILTER_ENABLES 8'h1c
`define CFC_OFF_FILTER_STEER_LOW 8'h20
`define CFC_OFF_DERIVED 8'h24
`define CFC_FLAG_MASK 16'h00ef
`define CFC_FILTER_EN_RESET 16'hffff
`define CFC_BUFCNT_RESERVED 3'h7
`define CFC_STEER_FIFO 4'hf
`define CFC_WARN_LIMIT 8'd96
`define CFC_PASSIVE_LIMIT 8'd128
`define CFC_BUSOFF_LIMIT 9'd256
`define CFC_IPT_TQ 4'h2
`define CFC_WAKE_FILTER_LEN 4'h8
`define CFC_AXI_OKAY 2'b00
`define CFC_AXI_SLVERR 2'b10
`endif

// File: inc/cfc_pkg.sv
// types shared by the can fifo, timing and filter register block
package cfc_pkg;
  typedef struct packed {
    logic invalid_msg;
    logic wakeup;
    logic almost_full;
    logic rx_overflow;
    logic rx_done;
    logic tx_done;
    logic rx_push;
    logic fifo_pop;
  } cfc_events_t;
  typedef struct packed {
    logic tx_err;
    logic rx_err;
    logic tx_ok;
    logic rx_ok;
  } cfc_err_evt_t;
  typedef struct packed {
    logic [1:0] sjw;
    logic [5:0] prescaler;
    logic [2:0] phase_two;
    logic [2:0] phase_one;
    logic [2:0] propagation;
    logic triple_sample_sel;
  } cfc_timing_t;
  typedef enum logic [1:0] {CFC_IDLE, CFC_WRESP, CFC_RRESP} cfc_bus_state_t;
endpackage

// File: testbench/cfc_regs_asserts.sv
// port-level assertions for the can register block
`timescale 1ns/100ps
module cfc_regs_asserts import cfc_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // events and results
  input wire logic filter_hit,
  input wire logic [3:0] filter_hit_num,
  input wire logic accept_valid,
  input wire logic accept_to_fifo,
  input wire logic rx_line,
  input wire logic wake_detect,
  input wire logic quantum_tick,
  input wire cfc_timing_t timing,
  input wire logic [5:0] buffer_total
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (reset);
  // gap stays zero until the first quantum tick under one prescaler value is seen
  logic [7:0] gap;
  logic [5:0] pre_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gap <= 8'h00;
      pre_q <= 6'h00;
    end else begin
      pre_q <= timing.prescaler;
      if (pre_q != timing.prescaler) gap <= 8'h00;
      else if (quantum_tick) gap <= 8'h01;
      else if (gap != 8'h00 && gap != 8'hff) gap <= gap + 8'h01;
    end
  end
  tick_gap_a: assert property (quantum_tick && gap != 8'h00 && pre_q == timing.prescaler
    |-> gap == {1'b0, timing.prescaler, 1'b0} + 8'h02) else $error("quantum period wrong");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
  buf_total_a: assert property (buffer_total inside {6'd4, 6'd6, 6'd8, 6'd12, 6'd16,
    6'd24, 6'd32}) else $error("buffer total illegal");
  accept_src_a: assert property (accept_valid |-> $past(filter_hit))
    else $error("accept without hit");
  high_filt_a: assert property (accept_valid && $past(filter_hit_num) > 4'h3
    |-> accept_to_fifo) else $error("upper filter not to fifo");
  wake_src_a: assert property (wake_detect |-> !$past(rx_line))
    else $error("wake without dominant line");
  cover property (accept_valid && accept_to_fifo);
  cover property (wake_detect);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind cfc_regs cfc_regs_asserts cfc_regs_asserts_i (.*);

// File: testbench/cfc_node_model.sv
// far-side can node: engine event pulses, filter hits and receive line
`timescale 1ns/100ps
module cfc_node_model import cfc_pkg::*; (
  // clock
  input wire logic ref_clk,
  // engine side
  output cfc_events_t evt,
  output cfc_err_evt_t err_evt,
  output logic rx_line,
  output logic filter_hit,
  output logic [3:0] filter_hit_num
);
  initial begin
    evt = '0;
    err_evt = '0;
    rx_line = 1'b1;
    filter_hit = 1'b0;
    filter_hit_num = 4'h0;
  end
  task automatic pulse(input cfc_events_t e);
    @(posedge ref_clk);
    evt <= e;
    @(posedge ref_clk);
    evt <= '0;
  endtask
  task automatic errs(input cfc_err_evt_t e, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      err_evt <= e;
      @(posedge ref_clk);
      err_evt <= '0;
    end
  endtask
  // number inverted after the hit to expose stale use
  task automatic hit(input logic [3:0] f);
    @(posedge ref_clk);
    filter_hit <= 1'b1;
    filter_hit_num <= f;
    @(posedge ref_clk);
    filter_hit <= 1'b0;
    filter_hit_num <= ~f;
  endtask
  // dominant for n cycles, then recessive idle
  task automatic dom(input int n);
    @(posedge ref_clk);
    rx_line <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rx_line <= 1'b1;
  endtask
endmodule

// File: testbench/test_cfc_regs.sv
// self-checking bench for the can register block
`timescale 1ns/100ps
`include "cfc_defines.svh"
module test_cfc_regs import cfc_pkg::*; ;
  localparam logic [1:0] OK = `CFC_AXI_OKAY;
  logic ref_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, filter_hit_num, accept_buffer, acc_buf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  cfc_events_t evt;
  cfc_err_evt_t err_evt;
  logic rx_line, sleep_active, filter_hit, irq, accept_valid, accept_to_fifo, wake_detect;
  logic sampled_bit, quantum_tick, acc_fifo;
  cfc_timing_t timing;
  logic [5:0] buffer_total;
  int error_cnt = 0, compares = 0, acc_cnt = 0, wake_cnt = 0, n0;
  // offsets in map order
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  logic [15:0] rv [9] = '{0, 0, 0, 0, 0, 0, 0, 16'hffff, 0};
  logic [15:0] wx [9] = '{16'he01f, 16'h1f1f, 0, 16'h00ef, 0, 16'h00ff, 16'h47ff, 16'hffff,
    16'hffff};
  logic [5:0] btx [8] = '{6'd4, 6'd6, 6'd8, 6'd12, 6'd16, 6'd24, 6'd32, 6'd32};
  int txn [5] = '{12, 0, 4, 0, 16};
  int rxn [5] = '{0, 96, 0, 32, 0};
  logic [15:0] ecx [5] = '{16'h6000, 16'h6060, 16'h8060, 16'h8080, 16'hff80};
  logic [15:0] efx [5] = '{16'h0520, 16'h0720, 16'h1720, 16'h1f20, 16'h2f20};
  logic [3:0] hf [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5};
  logic [4:0] hx [5] = '{5'h00, 5'h0e, 5'h03, 5'h10, 5'h10};
  logic [15:0] t2w [3] = '{16'h0028, 16'h0000, 16'h06c2};
  logic [17:0] t2x [3] = '{{8'hc3, 3'h5, 3'h5, 3'h0, 1'b0}, {8'hc3, 3'h1, 3'h0, 3'h0, 1'b0},
    {8'hc3, 3'h6, 3'h0, 3'h2, 1'b1}};
  cfc_regs #(.ADDR_W(8)) cfc_regs_i (.*);
  cfc_node_model cfc_node_model_i (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (accept_valid === 1'b1) begin
      acc_cnt <= acc_cnt + 1;
      acc_fifo <= accept_to_fifo;
      acc_buf <= accept_buffer;
    end
    if (wake_detect === 1'b1) wake_cnt <= wake_cnt + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h1, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {16'h0000, e});
    chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h1, er});
  endtask
  task automatic final_report;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // run takes under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sleep_active} = '0;
    s_axi_wstrb = 4'h3;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i], OK);
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], 16'hffff, OK);
      rd(ra[i], wx[i], OK);
    end
    wr(8'h40, 16'hffff, `CFC_AXI_SLVERR);
    rd(8'h40, 16'h0000, `CFC_AXI_SLVERR);
    rd(8'h02, 16'h0000, `CFC_AXI_SLVERR);
    for (int c = 0; c < 8; c++) begin
      wr(ra[0], {c[2:0], 13'h0000}, OK);
      repeat (2) @(posedge ref_clk);
      chk({26'h0, buffer_total}, {26'h0, btx[c]});
    end
    wr(ra[0], 16'hc005, OK);
    rd(ra[1], 16'h0505, OK);
    cfc_node_model_i.pulse(cfc_events_t'(8'h02));
    rd(ra[1], 16'h0605, OK);
    cfc_node_model_i.pulse(cfc_events_t'(8'h01));
    rd(ra[1], 16'h0606, OK);
    wr(ra[3], 16'h0000, OK);
    wr(ra[2], 16'h0000, OK);
    cfc_node_model_i.pulse(cfc_events_t'(8'hfc));
    rd(ra[2], 16'h00cf, OK);
    chk({31'h0, irq}, 32'h0);
    wr(ra[2], 16'h00ff, OK);
    rd(ra[2], 16'h00cf, OK);
    wr(ra[3], 16'h0001, OK);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(ra[2], 16'h00fe, OK);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rd(ra[2], 16'h00ce, OK);
    wr(ra[2], 16'h0000, OK);
    for (int s = 0; s < 5; s++) begin
      cfc_node_model_i.errs(cfc_err_evt_t'(4'h8), txn[s]);
      cfc_node_model_i.errs(cfc_err_evt_t'(4'h4), rxn[s]);
      rd(ra[4], ecx[s], OK);
      rd(ra[2], efx[s], OK);
    end
    wr(ra[2], 16'h0000, OK);
    rd(ra[2], 16'h2f20, OK);
    wr(ra[3], 16'h0020, OK);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(ra[8], 16'hf3e0, OK);
    for (int f = 0; f < 5; f++) begin
      n0 = acc_cnt;
      cfc_node_model_i.hit(hf[f]);
      repeat (2) @(posedge ref_clk);
      chk(acc_cnt - n0, 1);
      chk({27'h0, acc_fifo, acc_buf & {4{~acc_fifo}}}, {27'h0, hx[f]});
    end
    wr(ra[7], 16'hfffb, OK);
    n0 = acc_cnt;
    cfc_node_model_i.hit(4'h2);
    repeat (2) @(posedge ref_clk);
    chk(acc_cnt - n0, 0);
    wr(ra[6], 16'h4000, OK);
    sleep_active <= 1'b1;
    n0 = wake_cnt;
    cfc_node_model_i.dom(4);
    repeat (4) @(posedge ref_clk);
    chk(wake_cnt - n0, 0);
    cfc_node_model_i.dom(12);
    repeat (4) @(posedge ref_clk);
    chk(wake_cnt != n0, 1);
    wr(ra[6], 16'h0000, OK);
    n0 = wake_cnt;
    cfc_node_model_i.dom(2);
    repeat (4) @(posedge ref_clk);
    chk(wake_cnt != n0, 1);
    wr(ra[5], 16'h00c3, OK);
    for (int i = 0; i < 3; i++) begin
      wr(ra[6], t2w[i], OK);
      repeat (2) @(posedge ref_clk);
      chk({14'h0, timing}, {14'h0, t2x[i]});
    end
    rd(`CFC_OFF_DERIVED, 16'h0620, OK);
    repeat (40) @(posedge ref_clk);
    final_report();
  end
endmodule
